/* src/lco_pkg.sv */
// How it works
// - bits 2:0 pick overdrive of nominal plus 12.5 percent times (code plus one), 12.50 to 100.00 percent.
// - while overdrive is active the current target is nominal raised by the selected percentage, e.g. 101 gives +75.
// - bit 3 enables overdrive, ORed with the request pin; with both low the lamp runs at nominal current.
// - bits 7:4 select the timeout; zero disables it, N gives N times 2^22 lamp cycles.
package lco_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] LCO_CTRL_ADDR = 8'h00;
  localparam logic [7:0] LCO_STAT_ADDR = 8'h01;
  localparam logic [7:0] LCO_CTRL_RESET = 8'h00;
  localparam int LCO_LEVEL_LSB = 0;
  localparam int LCO_LEVEL_W = 3;
  localparam int LCO_EN_BIT = 3;
  localparam int LCO_TO_LSB = 4;
  localparam int LCO_TO_W = 4;
  localparam int LCO_TO_SHIFT = 22;
  // level step is 12.5 percent, i.e. one eighth: target = nominal * (8 + code + 1) / 8
  localparam int LCO_STEP_DIV = 8;
  localparam int LCO_PCT_W = 4;

  typedef struct packed {
    logic [3:0] timeout;
    logic enable;
    logic [2:0] level;
  } lco_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lco_bus_req_t;
endpackage

/* src/lco_ctrl.sv */
`timescale 1ns/1ps
module lco_ctrl #(
  parameter int CNT_W = 26,
  parameter int TO_SHIFT = lco_pkg::LCO_TO_SHIFT
) (
  input wire logic clk,
  input wire logic rst,
  input wire lco_pkg::lco_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  input wire logic overdrive_request_pin,
  input wire logic lamp_tick,
  output logic overdrive_active_q,
  output logic [3:0] overdrive_eighths_q
);
  // refuse a counter that cannot hold fifteen timeout units
  if (TO_SHIFT < 1 || CNT_W < TO_SHIFT + lco_pkg::LCO_TO_W) begin : g_bad_width
    $error("lco_ctrl: counter too narrow for timeout");
  end

  // ****************************************
  // register
  // ****************************************
  lco_pkg::lco_ctrl_t ctrl_q;
  logic timed_out_q;
  wire ctrl_hit = bus_req.wr && bus_req.addr == lco_pkg::LCO_CTRL_ADDR;
  wire [7:0] rd_mux = (bus_req.addr == lco_pkg::LCO_CTRL_ADDR) ? ctrl_q :
                      (bus_req.addr == lco_pkg::LCO_STAT_ADDR) ? {6'h00, timed_out_q, overdrive_active_q} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= lco_pkg::LCO_CTRL_RESET;
    end else if (ctrl_hit) begin
      ctrl_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // overdrive and timeout
  // ****************************************
  logic [CNT_W-1:0] cnt_q;

  function automatic logic [3:0] eighths_of(input logic [2:0] code);
    return 4'(code) + 4'h1;
  endfunction
  wire request = ctrl_q.enable | overdrive_request_pin;
  // N * 2^shift; zero code never compared since timeout disabled
  wire [CNT_W-1:0] limit = CNT_W'({ctrl_q.timeout, {TO_SHIFT{1'b0}}});
  wire to_on = ctrl_q.timeout != 4'h0;
  wire expire = to_on && overdrive_active_q && lamp_tick && (cnt_q + CNT_W'(1) >= limit);
  wire [3:0] eighths_d = request && !timed_out_q ? eighths_of(ctrl_q.level) : 4'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timed_out_q <= 1'h0;
    end else if (expire) begin
      // set wins over a request drop in the same cycle
      timed_out_q <= 1'h1;
    end else if (!request) begin
      timed_out_q <= 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!overdrive_active_q || expire) begin
      cnt_q <= '0;
    end else if (lamp_tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overdrive_active_q <= 1'b0;
      overdrive_eighths_q <= 4'h0;
    end else begin
      overdrive_active_q <= request && !timed_out_q && !expire;
      overdrive_eighths_q <= expire ? 4'h0 : eighths_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_level;
    @(posedge clk) disable iff (rst) (request && !timed_out_q && !expire)
      |=> overdrive_eighths_q == eighths_of($past(ctrl_q.level));
  endproperty
  a_level: assert property (p_level) else $error("overdrive level wrong");

  property p_nominal;
    @(posedge clk) disable iff (rst) !overdrive_active_q |-> overdrive_eighths_q == 4'h0;
  endproperty
  a_nominal: assert property (p_nominal) else $error("overdrive without active");

  property p_idle;
    @(posedge clk) disable iff (rst) !request |=> !overdrive_active_q;
  endproperty
  a_idle: assert property (p_idle) else $error("active with no request");

  property p_pin;
    @(posedge clk) disable iff (rst) (overdrive_request_pin && !timed_out_q && !expire) |=> overdrive_active_q;
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not start overdrive");

  property p_noto;
    @(posedge clk) disable iff (rst) !to_on |-> !expire;
  endproperty
  a_noto: assert property (p_noto) else $error("timeout while disabled");

  property p_expire;
    @(posedge clk) disable iff (rst) expire |=> !overdrive_active_q && timed_out_q;
  endproperty
  a_expire: assert property (p_expire) else $error("timeout did not end overdrive");

  property p_hold;
    @(posedge clk) disable iff (rst) (timed_out_q && request) |=> !overdrive_active_q;
  endproperty
  a_hold: assert property (p_hold) else $error("overdrive resumed without new request");

  property p_write;
    @(posedge clk) disable iff (rst) ctrl_hit |=> ctrl_q == $past(bus_req.wdata);
  endproperty
  a_write: assert property (p_write) else $error("control write lost");

  // ****************************************
  // register port checks
  // ****************************************
  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      !bus_req.rd
      |=> rdata_q == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_rdata_ctrl;
    @(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr == lco_pkg::LCO_CTRL_ADDR
      |=> rdata_q == $past(ctrl_q);
  endproperty
  a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control read back wrong");

  property p_rdata_stat;
    @(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr == lco_pkg::LCO_STAT_ADDR
      |=> rdata_q == {6'h00, $past(timed_out_q), $past(overdrive_active_q)};
  endproperty
  a_rdata_stat: assert property (p_rdata_stat) else $error("status read back wrong");

  property p_rdata_unmapped;
    @(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr != lco_pkg::LCO_CTRL_ADDR && bus_req.addr != lco_pkg::LCO_STAT_ADDR
      |=> rdata_q == 8'h00;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

  property p_ctrl_keep;
    @(posedge clk) disable iff (rst)
      !ctrl_hit
      |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed without write");

  property p_stat_nowrite;
    @(posedge clk) disable iff (rst)
      bus_req.wr && bus_req.addr == lco_pkg::LCO_STAT_ADDR
      |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_stat_nowrite: assert property (p_stat_nowrite) else $error("status write reached control");

  property p_rd_no_change;
    @(posedge clk) disable iff (rst)
      bus_req.rd
      |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_rd_no_change: assert property (p_rd_no_change) else $error("read altered control");

  // ****************************************
  // level and request checks
  // ****************************************
  property p_eighths_range;
    @(posedge clk) disable iff (rst)
      1'h1
      |-> overdrive_eighths_q <= 4'(lco_pkg::LCO_STEP_DIV);
  endproperty
  a_eighths_range: assert property (p_eighths_range) else $error("overdrive above full scale");

  property p_active_eighths;
    @(posedge clk) disable iff (rst)
      overdrive_active_q
      |-> overdrive_eighths_q != 4'h0;
  endproperty
  a_active_eighths: assert property (p_active_eighths) else $error("active at nominal level");

  property p_eighths_stable;
    @(posedge clk) disable iff (rst)
      overdrive_active_q && request && !expire && !$past(ctrl_hit)
      |=> $stable(overdrive_eighths_q);
  endproperty
  a_eighths_stable: assert property (p_eighths_stable) else $error("level moved without write");

  property p_enable_bit;
    @(posedge clk) disable iff (rst)
      ctrl_q.enable && !timed_out_q && !expire
      |=> overdrive_active_q;
  endproperty
  a_enable_bit: assert property (p_enable_bit) else $error("enable bit did not start overdrive");

  property p_idle_level;
    @(posedge clk) disable iff (rst)
      !request
      |=> overdrive_eighths_q == 4'h0;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("raised level with no request");

  property p_active_rise;
    @(posedge clk) disable iff (rst)
      $rose(overdrive_active_q)
      |-> $past(request);
  endproperty
  a_active_rise: assert property (p_active_rise) else $error("overdrive rose without request");

  property p_active_hold;
    @(posedge clk) disable iff (rst)
      overdrive_active_q && request && !expire
      |=> overdrive_active_q;
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("overdrive dropped early");

  // ****************************************
  // timeout checks
  // ****************************************
  property p_to_off_flag;
    @(posedge clk) disable iff (rst)
      !to_on && !timed_out_q
      |=> !timed_out_q;
  endproperty
  a_to_off_flag: assert property (p_to_off_flag) else $error("timed out while disabled");

  property p_cnt_idle;
    @(posedge clk) disable iff (rst)
      !overdrive_active_q
      |=> cnt_q == '0;
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("counter ran while nominal");

  property p_cnt_hold;
    @(posedge clk) disable iff (rst)
      overdrive_active_q && !lamp_tick
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");

  property p_cnt_step;
    @(posedge clk) disable iff (rst)
      overdrive_active_q && lamp_tick && !expire
      |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter missed a tick");

  property p_cnt_expire;
    @(posedge clk) disable iff (rst)
      expire
      |=> cnt_q == '0;
  endproperty
  a_cnt_expire: assert property (p_cnt_expire) else $error("counter kept after timeout");

  property p_drop;
    @(posedge clk) disable iff (rst)
      expire
      |=> overdrive_eighths_q == 4'h0;
  endproperty
  a_drop: assert property (p_drop) else $error("level kept after timeout");

  property p_to_cause;
    @(posedge clk) disable iff (rst)
      $rose(timed_out_q)
      |-> $past(expire);
  endproperty
  a_to_cause: assert property (p_to_cause) else $error("timeout flag without expiry");

  property p_flag_stays;
    @(posedge clk) disable iff (rst)
      timed_out_q && request
      |=> timed_out_q;
  endproperty
  a_flag_stays: assert property (p_flag_stays) else $error("timeout flag lost under request");

  property p_rearm;
    @(posedge clk) disable iff (rst)
      !request && !expire
      |=> !timed_out_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("request drop did not re-arm");

  property p_nominal_after_to;
    @(posedge clk) disable iff (rst)
      timed_out_q && request
      |=> overdrive_eighths_q == 4'h0;
  endproperty
  a_nominal_after_to: assert property (p_nominal_after_to) else $error("raised level after timeout");

  c_active: cover property (@(posedge clk) disable iff (rst) $rose(overdrive_active_q));
  c_expire: cover property (@(posedge clk) disable iff (rst) expire);
  c_full: cover property (@(posedge clk) disable iff (rst) overdrive_eighths_q == 4'h8);
  c_rearm: cover property (@(posedge clk) disable iff (rst) $fell(timed_out_q));
  c_pin: cover property (@(posedge clk) disable iff (rst) overdrive_request_pin && !ctrl_q.enable && overdrive_active_q);
endmodule

/* verif/tb_lamp_current_overdrive_ctrl.sv */
`timescale 1ns/1ps
module tb_lamp_current_overdrive_ctrl;
  logic clk, rst, pin, tick, act;
  lco_pkg::lco_bus_req_t req;
  logic [7:0] rdq;
  logic [3:0] eig;
  int errors, cmp_count;
  lco_ctrl #(.CNT_W(6), .TO_SHIFT(2)) u_dut (.clk(clk), .rst(rst), .bus_req(req), .rdata_q(rdq),
    .overdrive_request_pin(pin), .lamp_tick(tick), .overdrive_active_q(act), .overdrive_eighths_q(eig));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    idle(2);
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rdata", rdq, exp);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    idle(2);
  endtask
  task automatic t_levels;
    rd(lco_pkg::LCO_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(lco_pkg::LCO_CTRL_ADDR, {4'h0, 1'b1, 3'(i)});
      chk("eighths", 8'(eig), 8'(i + 1));
      rd(lco_pkg::LCO_CTRL_ADDR, {4'h0, 1'b1, 3'(i)});
    end
    wr(lco_pkg::LCO_CTRL_ADDR, 8'h05);
    chk("nominal", {act, eig}, 8'h00);
    @(posedge clk);
    pin <= 1'b1;
    idle(2);
    chk("pin", {act, eig}, 8'h16);
    @(posedge clk);
    pin <= 1'b0;
    idle(2);
    chk("pin off", {act, eig}, 8'h00);
    $display("levels and request done");
  endtask
  // timeout code n ends overdrive on tick n*4 with the shortened shift
  task automatic t_to(logic [3:0] n);
    wr(lco_pkg::LCO_CTRL_ADDR, 8'h00);
    wr(lco_pkg::LCO_CTRL_ADDR, {n, 4'ha});
    ticks(n * 4 - 1);
    chk("active", 8'(act), 8'h01);
    ticks(1);
    chk("expired", 8'(act), 8'h00);
    rd(lco_pkg::LCO_STAT_ADDR, 8'h02);
    wr(lco_pkg::LCO_CTRL_ADDR, 8'h00);
    wr(lco_pkg::LCO_CTRL_ADDR, 8'h0a);
    ticks(70);
    chk("no timeout", 8'(act), 8'h01);
    wr(8'h7f, 8'hff);
    wr(lco_pkg::LCO_STAT_ADDR, 8'hff);
    rd(8'h7f, 8'h00);
    rd(lco_pkg::LCO_CTRL_ADDR, 8'h0a);
    $display("timeout %0d done", n);
  endtask
  // reset in mid-run must drop overdrive and clear the control register
  task automatic t_reset;
    wr(lco_pkg::LCO_CTRL_ADDR, 8'h0f);
    chk("pre reset", {act, eig}, 8'h18);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset", {act, eig}, 8'h00);
    rd(lco_pkg::LCO_CTRL_ADDR, 8'h00);
    $display("reset done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    req = '0;
    pin = 1'b0;
    tick = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_levels();
    t_to(4'h1);
    t_to(4'hf);
    t_reset();
    conclude();
  end
  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule
